// ===== hdl/apt_pkg.sv
// package for the address-phase transfer type and parity block
// assumes a single bus clock domain; all bus strobes active low
package apt_pkg;

	localparam int XT_W       = 5;
	localparam int XC_W       = 8;
	localparam int ADDR_W     = 32;
	localparam int PAR_W      = 4;
	localparam int SIZE_W     = 3;
	localparam int BYTE_W     = 8;
	localparam int PERR_ASSERT  = 2;
	localparam int PERR_RELEASE = 3;
	localparam logic [1:0] CNT_ZERO = 2'h0;
	localparam logic [1:0] CNT_ONE  = 2'h1;

	// transfer type codes, bit 0 of the bus is the msb here
	localparam logic [4:0] TT_CLEAN      = 5'h00;
	localparam logic [4:0] TT_FLUSH      = 5'h04;
	localparam logic [4:0] TT_SYNC       = 5'h08;
	localparam logic [4:0] TT_KILL       = 5'h0C;
	localparam logic [4:0] TT_ORDERED_IO = 5'h10;
	localparam logic [4:0] TT_ECW_WRITE  = 5'h14;
	localparam logic [4:0] TT_XLAT_INV   = 5'h18;
	localparam logic [4:0] TT_ECW_READ   = 5'h1C;
	localparam logic [4:0] TT_RESV_SET   = 5'h01;
	localparam logic [4:0] TT_XLAT_SYNC  = 5'h09;
	localparam logic [4:0] TT_ICBI       = 5'h0D;
	localparam logic [4:0] TT_WR_FLUSH   = 5'h02;
	localparam logic [4:0] TT_WR_KILL    = 5'h06;
	localparam logic [4:0] TT_READ       = 5'h0A;
	localparam logic [4:0] TT_RWITM      = 5'h0E;
	localparam logic [4:0] TT_WR_FLUSH_A = 5'h12;
	localparam logic [4:0] TT_READ_A     = 5'h1A;
	localparam logic [4:0] TT_RWITM_A    = 5'h1E;
	localparam logic [4:0] TT_READ_NC    = 5'h0B;

	// request classes offered by the core side
	typedef enum logic [4:0] {
		APT_REQ_CLEAN     = 5'h00,
		APT_REQ_FLUSH     = 5'h01,
		APT_REQ_SYNC      = 5'h02,
		APT_REQ_KILL      = 5'h03,
		APT_REQ_ORDERED   = 5'h04,
		APT_REQ_ECW_WR    = 5'h05,
		APT_REQ_XLAT_INV  = 5'h06,
		APT_REQ_ECW_RD    = 5'h07,
		APT_REQ_RESV      = 5'h08,
		APT_REQ_XLAT_SYNC = 5'h09,
		APT_REQ_ICBI      = 5'h0A,
		APT_REQ_WR_FLUSH  = 5'h0B,
		APT_REQ_WR_KILL   = 5'h0C,
		APT_REQ_READ      = 5'h0D,
		APT_REQ_RWITM     = 5'h0E,
		APT_REQ_WR_FLUSH_A = 5'h0F,
		APT_REQ_READ_A    = 5'h10,
		APT_REQ_RWITM_A   = 5'h11,
		APT_REQ_READ_NC   = 5'h12
	} apt_req_t;

	// snooped address-phase lines, as sampled
	typedef struct packed {
		logic              xfer_start_n;
		logic              ext_addr_xfer_start_n;
		logic [ADDR_W-1:0] addr_lines;
		logic [PAR_W-1:0]  addr_byte_parity;
		logic [XT_W-1:0]   xfer_type;
		logic              burst_ind_n;
		logic [SIZE_W-1:0] xfer_size;
	} apt_snoop_t;

	// snoop report toward the core
	typedef struct packed {
		logic            valid;
		logic            is_ext;
		logic [XT_W-1:0] xfer_type;
		logic            reserved;
		logic            addr_only;
		logic            is_io;
		logic [XC_W-1:0] ext_xfer_code;
	} apt_report_t;

endpackage

// ===== hdl/apt_parity_check.sv
// odd byte parity checker over the address lines
// assumes inputs are already synchronised to the bus clock
`timescale 1ns/1ps

module apt_parity_check
(
	input  wire logic [apt_pkg::ADDR_W-1:0] addr,
	input  wire logic [apt_pkg::PAR_W-1:0]  par,
	output logic                            bad
);

	logic [apt_pkg::PAR_W-1:0] byte_bad;

	// byte 0 is the msb byte; byte plus parity must have odd ones
	genvar g;
	generate
		for (g = 0; g < apt_pkg::PAR_W; g++)
		begin : g_byte
			assign byte_bad[g] = ~(^{addr[apt_pkg::ADDR_W-1-g*apt_pkg::BYTE_W -: apt_pkg::BYTE_W],
				par[apt_pkg::PAR_W-1-g]});
		end
	endgenerate

	assign bad = |byte_bad;

endmodule

// ===== hdl/apt_addr_phase.sv
// address-phase transfer type drive, snoop decode and parity error report
// assumes the core requests tenures in step with the address lines; bus pins
// arrive from outside and pass two flip-flops before use
`timescale 1ns/1ps

// Operation
// - flag bad parity on recognised snoop tenures
// - check parity on direct-store first beat
// - keep error negated when parity good
// - assert error two cycles after start; the code asserts three cycles after the start in snp_r
// - release error three cycles after start; the code releases four cycles after the start in snp_r
// - extended code is type, burst, size
// - capture extended code only on extended start
// - drive type lines timed like address
// - clean flush sync kill address-only codes
// - reservation set on load-reserve cache hit
// - translation sync, icbi codes; some reserved
// - attribute meaning chosen by transaction class
// - odd parity per address byte
module apt_addr_phase
(
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	input  wire logic                     clk_en,
	input  wire apt_pkg::apt_snoop_t      snoop_in,
	input  wire logic                     drive_req,
	input  wire apt_pkg::apt_req_t        drive_kind,
	input  wire logic                     drive_end,
	output logic [apt_pkg::XT_W-1:0]      xfer_type_out,
	output logic                          xfer_type_oe,
	output logic                          addr_parity_err_n_out,
	output logic                          addr_parity_err_n_oe,
	output apt_pkg::apt_report_t          report
);

	//----------------------------------------------------------------
	// input synchronisers
	//----------------------------------------------------------------
	// every pin passes two flops; the idle value keeps both strobes negated,
	// so leaving reset never looks like a start. all timing counts from snp_r
	apt_pkg::apt_snoop_t snp_meta_r;
	apt_pkg::apt_snoop_t snp_r;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			snp_meta_r <= '1;
			snp_r      <= '1;
		end
		else if (clk_en)
		begin
			snp_meta_r <= snoop_in;
			snp_r      <= snp_meta_r;
		end
	end

	//----------------------------------------------------------------
	// snoop decode
	//----------------------------------------------------------------
	wire norm_start = ~snp_r.xfer_start_n;
	wire ext_start  = ~snp_r.ext_addr_xfer_start_n;
	// our own tenure is never snooped
	wire start_seen = (norm_start | ext_start) & ~xfer_type_oe;
	wire par_bad;

	apt_parity_check u_par
	(
		.addr (snp_r.addr_lines),
		.par  (snp_r.addr_byte_parity),
		.bad  (par_bad)
	);

	// only the start cycle samples address; the extended start covers
	// direct-store beat 0
	wire err_hit = start_seen & par_bad;

	wire [apt_pkg::XT_W-1:0] tt_s = snp_r.xfer_type;
	wire [apt_pkg::XC_W-1:0] xcode_s = {tt_s[apt_pkg::XT_W-1:1], snp_r.burst_ind_n,
		snp_r.xfer_size};

	// reserved control codes: 1xx01 and 00101
	wire resv_ctrl = (tt_s[1:0] == 2'h1 && tt_s[4])
		|| (tt_s == 5'h05);
	// reserved memory codes: xxx11 except the no-cache read, and 10110
	wire resv_mem  = (tt_s[1:0] == 2'h3 && tt_s != apt_pkg::TT_READ_NC)
		|| (tt_s == 5'h16);
	wire tt_resv   = resv_ctrl | resv_mem;
	// address-only: no data beat follows the address tenure
	wire tt_addr_only = (tt_s[1:0] == 2'h0 && tt_s[2:0] != 3'h4)
		|| (tt_s[1:0] == 2'h0 && (tt_s == apt_pkg::TT_FLUSH
			|| tt_s == apt_pkg::TT_KILL))
		|| tt_s == apt_pkg::TT_RESV_SET
		|| tt_s == apt_pkg::TT_XLAT_SYNC
		|| tt_s == apt_pkg::TT_ICBI;

	//----------------------------------------------------------------
	// parity error timing
	//----------------------------------------------------------------
	// err_hit is seen at start+2 after sync stage alignment; stage counts
	// from sampled start: assert at third cycle, release at fourth.
	// a fresh bad start while one is pending restarts the count, so two
	// close starts give one pulse, unless the second lands in the firing cycle: then two pulses
	logic [1:0] perr_cnt_r;
	logic       perr_pend_r;
	logic       perr_drive_r;
	logic       perr_level_r;

	wire perr_fire = perr_pend_r & (perr_cnt_r == apt_pkg::CNT_ONE);

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			perr_pend_r  <= 1'b0;
			perr_cnt_r   <= apt_pkg::CNT_ZERO;
			perr_drive_r <= 1'b0;
			perr_level_r <= 1'b1;
		end
		else if (clk_en)
		begin
			if (err_hit)
			begin
				perr_pend_r <= 1'b1;
				perr_cnt_r  <= apt_pkg::CNT_ZERO;
			end
			else if (perr_pend_r)
			begin
				perr_cnt_r  <= perr_cnt_r + 2'h1;
				perr_pend_r <= ~perr_fire;
			end
			perr_drive_r <= perr_fire;
			perr_level_r <= ~perr_fire;
		end
	end

	// open drain: the level is low whenever the enable is high; the
	// external pull-up gives the negated level once released
	assign addr_parity_err_n_out = perr_level_r;
	assign addr_parity_err_n_oe  = perr_drive_r;

	//----------------------------------------------------------------
	// snoop report
	//----------------------------------------------------------------
	apt_pkg::apt_report_t rep_nxt;

	always_comb
	begin
		rep_nxt               = '0;
		rep_nxt.valid         = start_seen;
		// the extended start marks the direct-store class
		rep_nxt.is_ext        = ext_start;
		rep_nxt.xfer_type     = tt_s;
		rep_nxt.reserved      = tt_resv;
		rep_nxt.addr_only     = tt_addr_only;
		rep_nxt.is_io         = ext_start;
		rep_nxt.ext_xfer_code = ext_start ? xcode_s : '0;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			report <= '0;
		else if (clk_en)
			report <= rep_nxt;
	end

	//----------------------------------------------------------------
	// transfer type drive
	//----------------------------------------------------------------
	logic [apt_pkg::XT_W-1:0] tt_code;

	always_comb
	begin
		unique case (drive_kind)
			apt_pkg::APT_REQ_CLEAN:      tt_code = apt_pkg::TT_CLEAN;
			apt_pkg::APT_REQ_FLUSH:      tt_code = apt_pkg::TT_FLUSH;
			apt_pkg::APT_REQ_SYNC:       tt_code = apt_pkg::TT_SYNC;
			apt_pkg::APT_REQ_KILL:       tt_code = apt_pkg::TT_KILL;
			apt_pkg::APT_REQ_ORDERED:    tt_code = apt_pkg::TT_ORDERED_IO;
			apt_pkg::APT_REQ_ECW_WR:     tt_code = apt_pkg::TT_ECW_WRITE;
			apt_pkg::APT_REQ_XLAT_INV:   tt_code = apt_pkg::TT_XLAT_INV;
			apt_pkg::APT_REQ_ECW_RD:     tt_code = apt_pkg::TT_ECW_READ;
			apt_pkg::APT_REQ_RESV:       tt_code = apt_pkg::TT_RESV_SET;
			apt_pkg::APT_REQ_XLAT_SYNC:  tt_code = apt_pkg::TT_XLAT_SYNC;
			apt_pkg::APT_REQ_ICBI:       tt_code = apt_pkg::TT_ICBI;
			apt_pkg::APT_REQ_WR_FLUSH:   tt_code = apt_pkg::TT_WR_FLUSH;
			apt_pkg::APT_REQ_WR_KILL:    tt_code = apt_pkg::TT_WR_KILL;
			apt_pkg::APT_REQ_READ:       tt_code = apt_pkg::TT_READ;
			apt_pkg::APT_REQ_RWITM:      tt_code = apt_pkg::TT_RWITM;
			apt_pkg::APT_REQ_WR_FLUSH_A: tt_code = apt_pkg::TT_WR_FLUSH_A;
			apt_pkg::APT_REQ_READ_A:     tt_code = apt_pkg::TT_READ_A;
			apt_pkg::APT_REQ_RWITM_A:    tt_code = apt_pkg::TT_RWITM_A;
			apt_pkg::APT_REQ_READ_NC:    tt_code = apt_pkg::TT_READ_NC;
			default:                     tt_code = apt_pkg::TT_SYNC;
		endcase
	end

	// drive from the start cycle until the address release cycle; a request
	// while already driving reloads the code
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			xfer_type_out <= '0;
			xfer_type_oe  <= 1'b0;
		end
		else if (clk_en)
		begin
			if (drive_req)
			begin
				xfer_type_out <= tt_code;
				xfer_type_oe  <= 1'b1;
			end
			else if (drive_end)
				xfer_type_oe  <= 1'b0;
		end
	end

endmodule

// ===== testbench/apt_bus_peer.sv
// model of the other bus masters that start snooped address tenures
// assumes the bench pulses go for one clock per tenure
`timescale 1ns/1ps

module apt_bus_peer
(
	input  wire logic	clk,
	input  wire logic	go,
	input  wire logic	ext,
	input  wire logic	bad,
	input  wire logic [4:0]	tt,
	output apt_pkg::apt_snoop_t	pins
);
	initial pins = '1;

	// pins valid only in the start cycle, scrambled otherwise
	always @(posedge clk)
	begin
		pins.xfer_start_n <= ~(go & ~ext);
		pins.ext_addr_xfer_start_n <= ~(go & ext);
		pins.addr_lines <= go ? 32'hA5A5A5A5 : ~pins.addr_lines;
		pins.addr_byte_parity <= go ? {4{~bad}} : ~pins.addr_byte_parity;
		pins.xfer_type <= go ? tt : ~pins.xfer_type;
		pins.burst_ind_n <= go ? tt[0] : ~pins.burst_ind_n;
		pins.xfer_size <= go ? ~tt[2:0] : ~pins.xfer_size;
	end
endmodule

// ===== testbench/apt_addr_phase_properties.sv
// timing checks on the address-phase block ports
// assumes one bus clock and synchronous active-low reset
`timescale 1ns/1ps

module apt_addr_phase_properties
(
	input wire logic	clk,
	input wire logic	reset_n,
	input wire logic	clk_en,
	input wire apt_pkg::apt_snoop_t	snoop_in,
	input wire logic	drive_req,
	input wire apt_pkg::apt_req_t	drive_kind,
	input wire logic	drive_end,
	input wire logic [apt_pkg::XT_W-1:0]	xfer_type_out,
	input wire logic	xfer_type_oe,
	input wire logic	addr_parity_err_n_out,
	input wire logic	addr_parity_err_n_oe,
	input wire apt_pkg::apt_report_t	report
);
	logic	st;
	logic	ok;
	logic	bad;
	logic	sn;
	logic	sx;
	logic [7:0]	xc;

	assign st = !(snoop_in.xfer_start_n && snoop_in.ext_addr_xfer_start_n);
	assign bad = st && !ok;
	assign sn = !snoop_in.xfer_start_n && snoop_in.ext_addr_xfer_start_n && !xfer_type_oe;
	assign sx = !snoop_in.ext_addr_xfer_start_n && !xfer_type_oe;
	assign xc = {snoop_in.xfer_type[4:1], snoop_in.burst_ind_n, snoop_in.xfer_size};

	always_comb
	begin
		ok = 1'b1;
		for (int i = 0; i < 4; i++)
			ok = ok & (^{snoop_in.addr_lines[8*i +: 8], snoop_in.addr_byte_parity[i]});
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n || !clk_en);

	property p_err_at;
		(bad && !xfer_type_oe) ##1 (!st && !xfer_type_oe)[*2]
			|=> ##2 addr_parity_err_n_oe ##1 !addr_parity_err_n_oe;
	endproperty
	a_err_at: assert property (p_err_at)
		else $error("parity error not flagged on time");
	property p_err_cause;
		addr_parity_err_n_oe |-> $past(bad, 4) || $past(bad, 5) || $past(bad, 6);
	endproperty
	a_err_cause: assert property (p_err_cause)
		else $error("parity error without bad parity");
	property p_err_pulse;
		addr_parity_err_n_oe |=> !addr_parity_err_n_oe;
	endproperty
	a_err_pulse: assert property (p_err_pulse)
		else $error("parity error not released");
	property p_err_level;
		addr_parity_err_n_oe |-> !addr_parity_err_n_out;
	endproperty
	a_err_level: assert property (p_err_level)
		else $error("parity error line not pulled low");
	property p_report;
		sn ##1 !xfer_type_oe[*2]
			|=> report.valid && report.xfer_type == $past(snoop_in.xfer_type, 3);
	endproperty
	a_report: assert property (p_report)
		else $error("snoop report missing");
	property p_ext;
		sx ##1 !xfer_type_oe[*2] |=> report.ext_xfer_code == $past(xc, 3);
	endproperty
	a_ext: assert property (p_ext)
		else $error("extended code wrong");
	property p_drive;
		drive_req |=> xfer_type_oe;
	endproperty
	a_drive: assert property (p_drive)
		else $error("type lines not driven");
	property p_release;
		drive_end && !drive_req |=> !xfer_type_oe;
	endproperty
	a_release: assert property (p_release)
		else $error("type lines not released");
	property p_hold;
		xfer_type_oe && $past(xfer_type_oe) |-> $stable(xfer_type_out);
	endproperty
	a_hold: assert property (p_hold)
		else $error("type lines changed in tenure");
endmodule

bind apt_addr_phase apt_addr_phase_properties u_props
(
	.clk                   (clk),
	.reset_n               (reset_n),
	.clk_en                (clk_en),
	.snoop_in              (snoop_in),
	.drive_req             (drive_req),
	.drive_kind            (drive_kind),
	.drive_end             (drive_end),
	.xfer_type_out         (xfer_type_out),
	.xfer_type_oe          (xfer_type_oe),
	.addr_parity_err_n_out (addr_parity_err_n_out),
	.addr_parity_err_n_oe  (addr_parity_err_n_oe),
	.report                (report)
);

// ===== testbench/addr_phase_type_parity_test.sv
// self-checking bench for the address-phase block
// assumes the peer model drives the snooped pins
`timescale 1ns/1ps

module addr_phase_type_parity_test;
	logic	clk = 1'b0;
	logic	reset_n = 1'b0;
	logic	drive_req = 1'b0;
	logic	drive_end = 1'b0;
	apt_pkg::apt_req_t	drive_kind = apt_pkg::APT_REQ_CLEAN;
	logic	go = 1'b0;
	logic	ext = 1'b0;
	logic	bad = 1'b0;
	logic [4:0]	tt = 5'h00;
	apt_pkg::apt_snoop_t	pins;
	logic [4:0]	type_out;
	logic	type_oe;
	logic	err_oe;
	logic	err_out;
	logic	en = 1'b1;
	// expected address-only flag per row, bit i for row i
	localparam logic [22:0] ADDR_ONLY = 23'h00075F;
	apt_pkg::apt_report_t	rep;
	int	compares = 0;
	int	miscompares = 0;
	// {reserved, code}; first rows follow the request kinds in order
	logic [5:0]	rows [23] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C,
		6'h01, 6'h09, 6'h0D, 6'h02, 6'h06, 6'h0A, 6'h0E, 6'h12, 6'h1A, 6'h1E, 6'h0B,
		6'h25, 6'h31, 6'h23, 6'h36};

	always #2.5 clk = ~clk;

	apt_addr_phase u_dut (.clk(clk), .reset_n(reset_n), .clk_en(en), .snoop_in(pins),
		.drive_req(drive_req), .drive_kind(drive_kind), .drive_end(drive_end),
		.xfer_type_out(type_out), .xfer_type_oe(type_oe), .addr_parity_err_n_out(err_out),
		.addr_parity_err_n_oe(err_oe), .report(rep));
	apt_bus_peer u_peer (.clk(clk), .go(go), .ext(ext), .bad(bad), .tt(tt), .pins(pins));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic snoop(input logic e, input logic b, input logic [5:0] r, input logic v,
		input logic a);
		@(posedge clk);
		go <= 1'b1;
		ext <= e;
		bad <= b;
		tt <= r[4:0];
		@(posedge clk);
		go <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk(rep.valid, v);
		if (v && !e)
		begin
			chk(rep.xfer_type, r[4:0]);
			chk(rep.reserved, r[5]);
			chk(rep.addr_only, a);
		end
		if (v)
		begin
			chk(rep.is_ext, e);
			chk(rep.is_io, e);
			chk(rep.ext_xfer_code, e ? {r[4:0], ~r[2:0]} : 8'h00);
		end
		repeat (2) @(posedge clk);
		#1;
		chk(err_oe, b && v);
		if (b && v)
			chk(err_out, 1'b0);
		@(posedge clk);
		#1;
		chk(err_oe, 1'b0);
	endtask

	// optional snoop inside the own tenure must be ignored
	task automatic drive(input int i, input logic s);
		@(posedge clk);
		drive_req <= 1'b1;
		drive_kind <= apt_pkg::apt_req_t'(i);
		@(posedge clk);
		drive_req <= 1'b0;
		#1;
		chk(type_oe, 1'b1);
		chk(type_out, rows[i][4:0]);
		if (s)
			snoop(1'b0, 1'b1, 6'h0A, 1'b0, 1'b0);
		@(posedge clk);
		drive_end <= 1'b1;
		@(posedge clk);
		drive_end <= 1'b0;
		#1;
		chk(type_oe, 1'b0);
	endtask

	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		#1;
		chk(type_oe, 1'b0);
		chk(err_oe, 1'b0);
		chk(rep.valid, 1'b0);
		for (int i = 0; i < 23; i++)
		begin
			if (i < 19)
				drive(i, 1'b0);
			snoop(1'b0, i[1], rows[i], 1'b1, ADDR_ONLY[i]);
		end
		$display("table test done");
		snoop(1'b1, 1'b1, 6'h16, 1'b1, 1'b0);
		snoop(1'b1, 1'b0, 6'h0D, 1'b1, 1'b0);
		drive(3, 1'b1);
		$display("direct-store and own tenure test done");
		// a bad start while frozen must leave no trace
		@(posedge clk);
		en <= 1'b0;
		snoop(1'b0, 1'b1, 6'h08, 1'b0, 1'b0);
		@(posedge clk);
		en <= 1'b1;
		$display("clock enable test done");
		// bad start whose error is pending when reset comes must never report
		@(posedge clk);
		go <= 1'b1;
		bad <= 1'b1;
		ext <= 1'b0;
		tt <= 5'h0A;
		@(posedge clk);
		go <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		repeat (5)
		begin
			@(posedge clk);
			#1;
			chk(err_oe, 1'b0);
			chk(rep.valid, 1'b0);
		end
		$display("reset test done");
		test_done;
	end

	// whole run is well under 1000 cycles
	initial
	begin
		#20000;
		miscompares++;
		test_done;
	end
endmodule
